/* hw/tmr8_ctrl.sv */
// two-channel 8-bit timer: counters, match/overflow flags, output pins, AXI4-Lite registers
//
// Overview of operation
// - ch0 counting ch1 overflow and ch1 counting ch0 match A together: neither counts.
// - ch0 match B flag sets when ch0 counter equals ch0 compare B.
// - ch0 match A flag sets when ch0 counter equals ch0 compare A.
// - ch0 overflow flag sets when ch0 counter wraps from FF to 00.
// - match B flag clears over the bus only by reading it as 1, then writing 0.
// - match A flag clears over the bus only by reading it as 1, then writing 0.
// - overflow flag clears only by reading it as 1, then writing 0.
// - transfer controller serving the match B request clears match B flag.
// - transfer controller serving the match A request clears match A flag.
// - writing 1 to any status flag has no effect.
// - ch0 status bit 4 gates converter start requests on ch0 match A.
// - ch0 match B drives ch0 pin: keep, low, high or toggle.
// - ch0 match A drives ch0 pin by its own select, same encoding.
// - ch1 match B flag sets when ch1 counter equals ch1 compare B.
// - ch1 match A flag sets when ch1 counter equals ch1 compare A.
// - ch1 overflow flag sets when ch1 counter wraps from FF to 00.
// - ch1 status bit 4 reads as 1, writes ignored.
// - ch1 match B drives ch1 pin: keep, low, high or toggle.
// - ch1 match A drives ch1 pin by its own select, same encoding.
// - clear select: never, on match A, on match B, or external input rising edge.
// - overflow request raised only while overflow flag and its enable are both 1.
`timescale 1ns/1ps
`include "tmr8_regs.svh"

module tmr8_ctrl
(
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic [`TMR8_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`TMR8_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [1:0]               ext_clear_in,
  input  wire logic [1:0]               dtc_served_a,
  input  wire logic [1:0]               dtc_served_b,
  output logic                          chan0_output_pin,
  output logic                          chan1_output_pin,
  output logic                          adc_start_req,
  output logic [1:0]                    match_a_irq,
  output logic [1:0]                    match_b_irq,
  output logic [1:0]                    overflow_irq
);

  // ==========
  // helpers
  function automatic logic hit(input logic [`TMR8_ADDR_W-1:0] a,
                               input logic [`TMR8_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic pin_act(input logic cur, input tmr8_pkg::tmr8_act_e act);
    pin_act = (act == tmr8_pkg::TMR8_ACT_LOW)    ? 1'b0 :
              (act == tmr8_pkg::TMR8_ACT_HIGH)   ? 1'b1 :
              (act == tmr8_pkg::TMR8_ACT_TOGGLE) ? ~cur : cur;
  endfunction

  function automatic logic is_mapped(input logic [`TMR8_ADDR_W-1:0] a);
    is_mapped = hit(a, `TMR8_OFF_STAT0) | hit(a, `TMR8_OFF_STAT1) |
                hit(a, `TMR8_OFF_CNT0)  | hit(a, `TMR8_OFF_CNT1)  |
                hit(a, `TMR8_OFF_CMPA0) | hit(a, `TMR8_OFF_CMPB0) |
                hit(a, `TMR8_OFF_CMPA1) | hit(a, `TMR8_OFF_CMPB1) |
                hit(a, `TMR8_OFF_CTRL0) | hit(a, `TMR8_OFF_CTRL1);
  endfunction

  // ==========
  // AXI4-Lite slave
  logic                     awready_reg;
  logic                     wready_reg;
  logic                     bvalid_reg;
  logic [1:0]               bresp_reg;
  logic                     arready_reg;
  logic                     rvalid_reg;
  logic [1:0]               rresp_reg;
  logic [31:0]              rdata_reg;
  logic                     aw_full_reg;
  logic                     w_full_reg;
  logic [`TMR8_ADDR_W-1:0]  waddr_reg;
  logic [7:0]               wbyte_reg;
  logic                     wlane_reg;
  logic [7:0]               rd_byte;

  wire aw_hs        = s_axi_awvalid & awready_reg;
  wire w_hs         = s_axi_wvalid & wready_reg;
  wire ar_hs        = s_axi_arvalid & arready_reg;
  wire do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
  wire w_full_next  = (w_full_reg | w_hs) & ~do_write;
  wire rvalid_next  = ar_hs | (rvalid_reg & ~s_axi_rready);
  wire wr_en        = do_write & wlane_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
    end
    else
    begin
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= do_write | (bvalid_reg & ~s_axi_bready);
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      waddr_reg <= '0;
      wbyte_reg <= `TMR8_RST_BYTE;
      wlane_reg <= 1'b0;
      bresp_reg <= `TMR8_RESP_OKAY;
      rresp_reg <= `TMR8_RESP_OKAY;
      rdata_reg <= '0;
    end
    else
    begin
      if (aw_hs)
        waddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wbyte_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (do_write)
        bresp_reg <= is_mapped(waddr_reg) ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
      if (ar_hs)
      begin
        rresp_reg <= is_mapped(s_axi_araddr) ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
        rdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ==========
  // per-channel state
  logic [7:0]             cnt_reg    [2];
  logic [7:0]             cmpa_reg   [2];
  logic [7:0]             cmpb_reg   [2];
  tmr8_pkg::tmr8_ctrl_s   ctrl_reg   [2];
  tmr8_pkg::tmr8_cfg_s    cfg_reg    [2];
  logic [1:0]             ma_reg;
  logic [1:0]             mb_reg;
  logic [1:0]             ovf_reg;
  logic [1:0]             arm_ma_reg;
  logic [1:0]             arm_mb_reg;
  logic [1:0]             arm_ovf_reg;
  logic [1:0]             eqa_dly_reg;
  logic [1:0]             eqb_dly_reg;
  logic [1:0]             ext_dly_reg;
  logic [1:0]             pin_reg;
  logic [1:0]             ma_irq_reg;
  logic [1:0]             mb_irq_reg;
  logic [1:0]             ovf_irq_reg;
  logic                   adc_reg;

  logic [1:0]             evt_a;
  logic [1:0]             evt_b;
  logic [1:0]             ovf_evt;
  logic [1:0]             tick;

  // ==========
  // count sources and cascade
  wire casc0     = (ctrl_reg[0].clk_sel == tmr8_pkg::TMR8_CKS_CASCADE);
  wire casc1     = (ctrl_reg[1].clk_sel == tmr8_pkg::TMR8_CKS_CASCADE);
  wire casc_loop = casc0 & casc1;
  assign tick[0] = (ctrl_reg[0].clk_sel == tmr8_pkg::TMR8_CKS_CORE) |
                   (casc0 & ~casc_loop & ovf_evt[1]);
  assign tick[1] = (ctrl_reg[1].clk_sel == tmr8_pkg::TMR8_CKS_CORE) |
                   (casc1 & ~casc_loop & evt_a[0]);

  // ==========
  // register read mux
  wire [7:0] stat0 = {mb_reg[0], ma_reg[0], ovf_reg[0], cfg_reg[0]};
  wire [7:0] stat1 = {mb_reg[1], ma_reg[1], ovf_reg[1], `TMR8_RSVD_VAL,
                      cfg_reg[1].act_b, cfg_reg[1].act_a};
  assign rd_byte =
    hit(s_axi_araddr, `TMR8_OFF_STAT0) ? stat0 :
    hit(s_axi_araddr, `TMR8_OFF_STAT1) ? stat1 :
    hit(s_axi_araddr, `TMR8_OFF_CNT0)  ? cnt_reg[0] :
    hit(s_axi_araddr, `TMR8_OFF_CNT1)  ? cnt_reg[1] :
    hit(s_axi_araddr, `TMR8_OFF_CMPA0) ? cmpa_reg[0] :
    hit(s_axi_araddr, `TMR8_OFF_CMPB0) ? cmpb_reg[0] :
    hit(s_axi_araddr, `TMR8_OFF_CMPA1) ? cmpa_reg[1] :
    hit(s_axi_araddr, `TMR8_OFF_CMPB1) ? cmpb_reg[1] :
    hit(s_axi_araddr, `TMR8_OFF_CTRL0) ? ctrl_reg[0] :
    hit(s_axi_araddr, `TMR8_OFF_CTRL1) ? ctrl_reg[1] : `TMR8_RST_BYTE;

  // ==========
  // channel logic
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_chan
      wire [`TMR8_ADDR_W-1:0] off_stat = (gi == 0) ? `TMR8_OFF_STAT0 : `TMR8_OFF_STAT1;
      wire [`TMR8_ADDR_W-1:0] off_cnt  = (gi == 0) ? `TMR8_OFF_CNT0  : `TMR8_OFF_CNT1;
      wire [`TMR8_ADDR_W-1:0] off_cmpa = (gi == 0) ? `TMR8_OFF_CMPA0 : `TMR8_OFF_CMPA1;
      wire [`TMR8_ADDR_W-1:0] off_cmpb = (gi == 0) ? `TMR8_OFF_CMPB0 : `TMR8_OFF_CMPB1;
      wire [`TMR8_ADDR_W-1:0] off_ctrl = (gi == 0) ? `TMR8_OFF_CTRL0 : `TMR8_OFF_CTRL1;

      wire st_rd   = ar_hs & hit(s_axi_araddr, off_stat);
      wire st_wr   = wr_en & hit(waddr_reg, off_stat);
      wire cnt_wr  = wr_en & hit(waddr_reg, off_cnt);
      wire cmpa_wr = wr_en & hit(waddr_reg, off_cmpa);
      wire cmpb_wr = wr_en & hit(waddr_reg, off_cmpb);
      wire ctrl_wr = wr_en & hit(waddr_reg, off_ctrl);

      wire eq_a    = (cnt_reg[gi] == cmpa_reg[gi]);
      wire eq_b    = (cnt_reg[gi] == cmpb_reg[gi]);
      assign evt_a[gi] = eq_a & ~eqa_dly_reg[gi];
      assign evt_b[gi] = eq_b & ~eqb_dly_reg[gi];
      wire ext_rise = ext_clear_in[gi] & ~ext_dly_reg[gi];

      wire clr_now = ((ctrl_reg[gi].clr_sel == tmr8_pkg::TMR8_CLR_MA)  & evt_a[gi]) |
                     ((ctrl_reg[gi].clr_sel == tmr8_pkg::TMR8_CLR_MB)  & evt_b[gi]) |
                     ((ctrl_reg[gi].clr_sel == tmr8_pkg::TMR8_CLR_EXT) & ext_rise);
      assign ovf_evt[gi] = tick[gi] & ~clr_now & (cnt_reg[gi] == `TMR8_CNT_MAX);

      // a write of 0 clears only after a read that saw the flag set; set wins
      wire clr_ma  = (st_wr & ~wbyte_reg[`TMR8_BIT_MA] & arm_ma_reg[gi]) |
                     dtc_served_a[gi];
      wire clr_mb  = (st_wr & ~wbyte_reg[`TMR8_BIT_MB] & arm_mb_reg[gi]) |
                     dtc_served_b[gi];
      wire clr_ovf = st_wr & ~wbyte_reg[`TMR8_BIT_OVF] & arm_ovf_reg[gi];
      wire ma_next  = evt_a[gi] | (ma_reg[gi] & ~clr_ma);
      wire mb_next  = evt_b[gi] | (mb_reg[gi] & ~clr_mb);
      wire ovf_next = ovf_evt[gi] | (ovf_reg[gi] & ~clr_ovf);

      wire [7:0] cnt_next = cnt_wr   ? wbyte_reg :
                            clr_now  ? `TMR8_RST_BYTE :
                            tick[gi] ? 8'(cnt_reg[gi] + 8'h01) : cnt_reg[gi];

      // match A applied first, match B last when both land together
      wire pin_a    = evt_a[gi] ? pin_act(pin_reg[gi], cfg_reg[gi].act_a) : pin_reg[gi];
      wire pin_next = evt_b[gi] ? pin_act(pin_a, cfg_reg[gi].act_b) : pin_a;

      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          cnt_reg[gi]     <= `TMR8_RST_BYTE;
          cmpa_reg[gi]    <= `TMR8_RST_CMP;
          cmpb_reg[gi]    <= `TMR8_RST_CMP;
          ctrl_reg[gi]    <= tmr8_pkg::tmr8_ctrl_s'(`TMR8_RST_BYTE);
          cfg_reg[gi]     <= '0;
          ma_reg[gi]      <= 1'b0;
          mb_reg[gi]      <= 1'b0;
          ovf_reg[gi]     <= 1'b0;
          arm_ma_reg[gi]  <= 1'b0;
          arm_mb_reg[gi]  <= 1'b0;
          arm_ovf_reg[gi] <= 1'b0;
          eqa_dly_reg[gi] <= 1'b0;
          eqb_dly_reg[gi] <= 1'b0;
          ext_dly_reg[gi] <= 1'b0;
          pin_reg[gi]     <= 1'b0;
          ma_irq_reg[gi]  <= 1'b0;
          mb_irq_reg[gi]  <= 1'b0;
          ovf_irq_reg[gi] <= 1'b0;
        end
        else
        begin
          cnt_reg[gi]     <= cnt_next;
          ma_reg[gi]      <= ma_next;
          mb_reg[gi]      <= mb_next;
          ovf_reg[gi]     <= ovf_next;
          // arming drops on any status write; a read in the same cycle re-arms
          arm_ma_reg[gi]  <= (st_rd & ma_reg[gi]) | (arm_ma_reg[gi] & ~st_wr);
          arm_mb_reg[gi]  <= (st_rd & mb_reg[gi]) | (arm_mb_reg[gi] & ~st_wr);
          arm_ovf_reg[gi] <= (st_rd & ovf_reg[gi]) | (arm_ovf_reg[gi] & ~st_wr);
          eqa_dly_reg[gi] <= eq_a;
          eqb_dly_reg[gi] <= eq_b;
          ext_dly_reg[gi] <= ext_clear_in[gi];
          pin_reg[gi]     <= pin_next;
          ma_irq_reg[gi]  <= ma_next & ctrl_reg[gi].ma_irq_en;
          mb_irq_reg[gi]  <= mb_next & ctrl_reg[gi].mb_irq_en;
          ovf_irq_reg[gi] <= ovf_next & ctrl_reg[gi].ovf_irq_en;
          if (cmpa_wr)
            cmpa_reg[gi]  <= wbyte_reg;
          if (cmpb_wr)
            cmpb_reg[gi]  <= wbyte_reg;
          if (ctrl_wr)
            ctrl_reg[gi]  <= tmr8_pkg::tmr8_ctrl_s'(wbyte_reg);
          if (st_wr)
          begin
            cfg_reg[gi].act_b <= tmr8_pkg::tmr8_act_e'(wbyte_reg[`TMR8_BIT_ACTB_HI:`TMR8_BIT_ACTB_LO]);
            cfg_reg[gi].act_a <= tmr8_pkg::tmr8_act_e'(wbyte_reg[`TMR8_BIT_ACTA_HI:`TMR8_BIT_ACTA_LO]);
            // channel 1 bit 4 is fixed; only channel 0 keeps the trigger enable
            cfg_reg[gi].adc_trig_en <= (gi == 0) ? wbyte_reg[`TMR8_BIT_ADC_TRIGGER_ENABLE] : 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========
  // converter start request and pins
  always_ff @(posedge core_clk)
  begin
    if (reset)
      adc_reg <= 1'b0;
    else
      adc_reg <= evt_a[0] & cfg_reg[0].adc_trig_en;
  end

  assign chan0_output_pin = pin_reg[0];
  assign chan1_output_pin = pin_reg[1];
  assign adc_start_req    = adc_reg;
  assign match_a_irq      = ma_irq_reg;
  assign match_b_irq      = mb_irq_reg;
  assign overflow_irq     = ovf_irq_reg;

endmodule

/* hw/tmr8_regs.svh */
// register offsets, field positions, reset values and codes of the two-channel 8-bit timer
`ifndef TMR8_REGS_SVH
`define TMR8_REGS_SVH

`define TMR8_ADDR_W        8
`define TMR8_OFF_STAT0     8'h00
`define TMR8_OFF_STAT1     8'h04
`define TMR8_OFF_CNT0      8'h08
`define TMR8_OFF_CNT1      8'h0C
`define TMR8_OFF_CMPA0     8'h10
`define TMR8_OFF_CMPB0     8'h14
`define TMR8_OFF_CMPA1     8'h18
`define TMR8_OFF_CMPB1     8'h1C
`define TMR8_OFF_CTRL0     8'h20
`define TMR8_OFF_CTRL1     8'h24

`define TMR8_BIT_MB        7
`define TMR8_BIT_MA        6
`define TMR8_BIT_OVF       5
`define TMR8_BIT_ADC_TRIGGER_ENABLE      4
`define TMR8_BIT_RSVD      4
`define TMR8_BIT_ACTB_HI   3
`define TMR8_BIT_ACTB_LO   2
`define TMR8_BIT_ACTA_HI   1
`define TMR8_BIT_ACTA_LO   0

`define TMR8_BIT_MBIE      7
`define TMR8_BIT_MAIE      6
`define TMR8_BIT_OVERFLOW_IRQ_ENABLE      5
`define TMR8_BIT_CLR_HI    4
`define TMR8_BIT_CLR_LO    3
`define TMR8_BIT_CKS_HI    2
`define TMR8_BIT_CKS_LO    0

`define TMR8_RST_BYTE      8'h00
`define TMR8_RST_CMP       8'hFF
`define TMR8_CNT_MAX       8'hFF
`define TMR8_RSVD_VAL      1'b1

`define TMR8_RESP_OKAY     2'h0
`define TMR8_RESP_SLVERR   2'h2

`endif

/* hw/tmr8_pkg.sv */
// types shared by the two-channel 8-bit timer
package tmr8_pkg;

  typedef enum logic [1:0] {
    TMR8_ACT_KEEP   = 2'b00,
    TMR8_ACT_LOW    = 2'b01,
    TMR8_ACT_HIGH   = 2'b10,
    TMR8_ACT_TOGGLE = 2'b11
  } tmr8_act_e;

  typedef enum logic [1:0] {
    TMR8_CLR_NONE  = 2'b00,
    TMR8_CLR_MA    = 2'b01,
    TMR8_CLR_MB    = 2'b10,
    TMR8_CLR_EXT   = 2'b11
  } tmr8_clr_e;

  typedef enum logic [2:0] {
    TMR8_CKS_STOP    = 3'b000,
    TMR8_CKS_CORE    = 3'b001,
    TMR8_CKS_CASCADE = 3'b100
  } tmr8_cks_e;

  typedef struct packed {
    logic      mb_irq_en;
    logic      ma_irq_en;
    logic      ovf_irq_en;
    tmr8_clr_e clr_sel;
    logic [2:0] clk_sel;
  } tmr8_ctrl_s;

  typedef struct packed {
    logic      adc_trig_en;
    tmr8_act_e act_b;
    tmr8_act_e act_a;
  } tmr8_cfg_s;

endpackage

/* tb/tmr8_ctrl_assertions.sv */
// concurrent checks on the register bus and converter start output of the two-channel timer
`timescale 1ns/1ps
`include "tmr8_regs.svh"

module tmr8_ctrl_assertions
(
  input wire logic                    core_clk,
  input wire logic                    reset,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [`TMR8_ADDR_W-1:0] s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    adc_start_req
);
  // ==========
  // read address tracking
  logic [`TMR8_ADDR_W-1:0] ar_addr_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ar_addr_reg <= '0;
    else if (s_axi_arvalid && s_axi_arready)
      ar_addr_reg <= s_axi_araddr;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========
  // properties
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  bresp_code_a: assert property (s_axi_bvalid |->
    s_axi_bresp inside {`TMR8_RESP_OKAY, `TMR8_RESP_SLVERR}) else $error("bad write response");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer not one cycle later");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready during write");
  reserved_bit_a: assert property (s_axi_rvalid && ar_addr_reg == `TMR8_OFF_STAT1 |->
    s_axi_rdata[`TMR8_BIT_RSVD] && s_axi_rresp == `TMR8_RESP_OKAY)
    else $error("channel 1 reserved bit not one");
  unmapped_read_a: assert property (s_axi_rvalid && ar_addr_reg > `TMR8_OFF_CTRL1 |->
    s_axi_rresp == `TMR8_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  adc_pulse_a: assert property (adc_start_req |=> !adc_start_req)
    else $error("converter start longer than one cycle");
endmodule

/* tb/tmr8_ctrl_tb_top.sv */
// self-checking bench for the two-channel 8-bit timer
`timescale 1ns/1ps
`include "tmr8_regs.svh"

module tmr8_ctrl_tb_top;
  localparam int TIMEOUT_CYCLES = 20000;
  logic                    core_clk;
  logic                    reset;
  logic [`TMR8_ADDR_W-1:0] s_axi_awaddr;
  logic                    s_axi_awvalid;
  logic                    s_axi_awready;
  logic [31:0]             s_axi_wdata;
  logic                    s_axi_wvalid;
  logic                    s_axi_wready;
  logic [1:0]              s_axi_bresp;
  logic                    s_axi_bvalid;
  logic                    s_axi_bready;
  logic [`TMR8_ADDR_W-1:0] s_axi_araddr;
  logic                    s_axi_arvalid;
  logic                    s_axi_arready;
  logic [31:0]             s_axi_rdata;
  logic [1:0]              s_axi_rresp;
  logic                    s_axi_rvalid;
  logic                    s_axi_rready;
  logic [1:0]              ext_clear_in;
  logic [1:0]              dtc_served_a;
  logic [1:0]              dtc_served_b;
  logic                    chan0_output_pin;
  logic                    chan1_output_pin;
  logic                    adc_start_req;
  logic [1:0]              match_a_irq;
  logic [1:0]              match_b_irq;
  logic [1:0]              overflow_irq;
  logic [7:0]              rd_byte;
  logic [1:0]              resp_seen;
  int                      mismatches, total_checks, cycles, adc_pulses;

  tmr8_ctrl i_tmr8_ctrl (
    .core_clk(core_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_clear_in(ext_clear_in), .dtc_served_a(dtc_served_a), .dtc_served_b(dtc_served_b),
    .chan0_output_pin(chan0_output_pin), .chan1_output_pin(chan1_output_pin),
    .adc_start_req(adc_start_req), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
    .overflow_irq(overflow_irq));

  // ==========
  // clock, timeout and start monitor
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (adc_start_req === 1'b1)
      adc_pulses <= adc_pulses + 1;
    if (cycles == TIMEOUT_CYCLES)
    begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  // ==========
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h0, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    resp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [7:0] addr);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    rd_byte = s_axi_rdata[7:0];
    resp_seen = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic test_registers();
    axi_read(`TMR8_OFF_STAT0);
    check("status0 reset", rd_byte, 8'h00);
    axi_read(`TMR8_OFF_STAT1);
    check("status1 reset", rd_byte, 8'h10);
    axi_read(`TMR8_OFF_CMPA0);
    check("compare a0 reset", rd_byte, `TMR8_RST_CMP);
    axi_write(`TMR8_OFF_STAT1, 8'hFF);
    axi_read(`TMR8_OFF_STAT1);
    check("status1 ones written", rd_byte, 8'h1F);
    axi_write(`TMR8_OFF_STAT1, 8'h00);
    axi_read(`TMR8_OFF_STAT1);
    check("status1 zeros written", rd_byte, 8'h10);
    axi_write(8'h28, 8'h5A);
    check("unmapped write resp", resp_seen, `TMR8_RESP_SLVERR);
    axi_read(8'h28);
    check("unmapped read resp", resp_seen, `TMR8_RESP_SLVERR);
    $display("test registers done");
  endtask

  task automatic test_ch0_flags();
    axi_write(`TMR8_OFF_CMPA0, 8'h10);
    axi_write(`TMR8_OFF_CMPB0, 8'h20);
    axi_write(`TMR8_OFF_STAT0, 8'h16);
    axi_write(`TMR8_OFF_CNT0, 8'h00);
    axi_write(`TMR8_OFF_CTRL0, 8'hE1);
    while (match_a_irq[0] !== 1'b1) @(posedge core_clk);
    check("pin0 on match a", chan0_output_pin, 1'b1);
    while (match_b_irq[0] !== 1'b1) @(posedge core_clk);
    check("pin0 on match b", chan0_output_pin, 1'b0);
    while (overflow_irq[0] !== 1'b1) @(posedge core_clk);
    axi_write(`TMR8_OFF_CTRL0, 8'hC0);
    check("overflow irq masked", overflow_irq[0], 1'b0);
    check("converter starts", adc_pulses, 1);
    axi_write(`TMR8_OFF_STAT0, 8'h16);
    check("match a kept", match_a_irq[0], 1'b1);
    check("match b kept", match_b_irq[0], 1'b1);
    axi_read(`TMR8_OFF_STAT0);
    check("status0 flags", rd_byte, 8'hF6);
    axi_write(`TMR8_OFF_STAT0, 8'h16);
    axi_read(`TMR8_OFF_STAT0);
    check("status0 cleared", rd_byte, 8'h16);
    check("match a irq cleared", match_a_irq[0], 1'b0);
    $display("test ch0 done");
  endtask

  task automatic test_ch1_pin_dtc();
    axi_write(`TMR8_OFF_CMPA1, 8'h05);
    axi_write(`TMR8_OFF_CMPB1, 8'h08);
    axi_write(`TMR8_OFF_STAT1, 8'h0C);
    axi_write(`TMR8_OFF_CNT1, 8'h00);
    axi_write(`TMR8_OFF_CTRL1, 8'hD1);
    while (match_a_irq[1] !== 1'b1) @(posedge core_clk);
    check("pin1 kept on match a", chan1_output_pin, 1'b0);
    while (match_b_irq[1] !== 1'b1) @(posedge core_clk);
    check("pin1 toggled on match b", chan1_output_pin, 1'b1);
    while (chan1_output_pin !== 1'b0) @(posedge core_clk);
    axi_read(`TMR8_OFF_CNT1);
    check("counter1 cleared on match b", rd_byte, 8'h01);
    axi_write(`TMR8_OFF_CTRL1, 8'hD0);
    dtc_served_a <= 2'b10;
    @(posedge core_clk);
    dtc_served_a <= 2'b00;
    @(posedge core_clk);
    check("transfer clears match a", match_a_irq[1], 1'b0);
    check("match b untouched", match_b_irq[1], 1'b1);
    dtc_served_b <= 2'b10;
    @(posedge core_clk);
    dtc_served_b <= 2'b00;
    @(posedge core_clk);
    check("transfer clears match b", match_b_irq[1], 1'b0);
    axi_read(`TMR8_OFF_STAT1);
    check("status1 after transfer", rd_byte, 8'h1C);
    $display("test ch1 done");
  endtask

  task automatic test_ext_clear_cascade();
    axi_write(`TMR8_OFF_CTRL0, 8'h18);
    axi_write(`TMR8_OFF_CNT0, 8'h55);
    ext_clear_in <= 2'b01;
    repeat (2) @(posedge core_clk);
    ext_clear_in <= 2'b00;
    axi_read(`TMR8_OFF_CNT0);
    check("external clear", rd_byte, 8'h00);
    axi_write(`TMR8_OFF_CTRL0, 8'h04);
    axi_write(`TMR8_OFF_CTRL1, 8'h04);
    axi_write(`TMR8_OFF_CNT1, 8'h00);
    axi_write(`TMR8_OFF_CNT0, 8'h10);
    repeat (30) @(posedge core_clk);
    axi_read(`TMR8_OFF_CNT1);
    check("cascade loop ch1 still", rd_byte, 8'h00);
    axi_read(`TMR8_OFF_CNT0);
    check("cascade loop ch0 still", rd_byte, 8'h10);
    axi_write(`TMR8_OFF_CTRL1, 8'h01);
    axi_write(`TMR8_OFF_CNT1, 8'hF0);
    repeat (30) @(posedge core_clk);
    axi_read(`TMR8_OFF_CNT0);
    check("ch0 counts ch1 overflow", rd_byte, 8'h11);
    $display("test cascade done");
  endtask

  // ==========
  // main sequence
  initial
  begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {ext_clear_in, dtc_served_a, dtc_served_b} = 6'h00;
    {mismatches, total_checks, cycles, adc_pulses} = 128'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    test_registers();
    test_ch0_flags();
    test_ch1_pin_dtc();
    test_ext_clear_cascade();
    wrap_up();
  end
endmodule

bind tmr8_ctrl tmr8_ctrl_assertions i_tmr8_ctrl_assertions (
  .core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .adc_start_req(adc_start_req));
